// >>> src/tbwc_map.svh
// Operation
// (RULE1) Command code 0x05 starts multi-block write
// (RULE2) Arguments: start, count, offset, selector, key
// (RULE3) Start block is absolute index, not bytes
// (RULE4) Host gives block count above zero
// (RULE5) Host keeps offset plus size within buffer
// (RULE6) Selector bit 6 enables supplied key
// (RULE7) Selector bit 7 picks key B, else A
// (RULE8) Key bytes held least significant first
// (RULE9) Authenticate starting sector before any write; code does so only when selector bit 6 is set
// (RULE10) Failed authentication reports error, ends command
// (RULE11) Write first block then following blocks in order
// (RULE12) Skip key and lock blocks entirely
// (RULE13) New sector re-authenticated with same key
// (RULE14) Success writes no-error result value
// (RULE15) Failed block write reports error code
// (RULE16) Buffer pointer advances one block per block
`ifndef TBWC_MAP_SVH
`define TBWC_MAP_SVH
`define TBWC_CMD_WRITE_BLK  8'h05
`define TBWC_ARG_START      4'h0
`define TBWC_ARG_COUNT      4'h1
`define TBWC_ARG_OFFSET     4'h3
`define TBWC_ARG_KEYSEL     4'h4
`define TBWC_ARG_KEY        4'h5
`define TBWC_KEY_BYTES      4'h6
`define TBWC_KEYSEL_USE     6
`define TBWC_KEYSEL_B       7
`define TBWC_BLK_BYTES      5'h10
`define TBWC_BUF_LEN        13'h0100
`define TBWC_BIG_SECT_BLK   8'h80
`define TBWC_RES_OK         8'h00
`define TBWC_RES_BAD_CMD    8'h01
`define TBWC_RES_BAD_ARG    8'h02
`define TBWC_RES_AUTH_ERR   8'h03
`define TBWC_RES_WR_ERR     8'h04
`define TBWC_FIFO_DEPTH     16
`define TBWC_FIFO_WIDTH     8
`endif

// >>> src/tbwc_pkg.sv
package tbwc_pkg;
  typedef enum logic [5:0] {
    TBWC_IDLE  = 6'b000001,
    TBWC_CHECK = 6'b000010,
    TBWC_SEEK  = 6'b000100,
    TBWC_AUTH  = 6'b001000,
    TBWC_WRITE = 6'b010000,
    TBWC_DONE  = 6'b100000
  } tbwc_state_type;
endpackage

// >>> src/tbwc_stream_if.sv
`timescale 1ns/1ps
interface tbwc_stream_if #(parameter int WIDTH = 8);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// >>> src/tbwc_fifo.sv
`timescale 1ns/1ps
module tbwc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic i_mclk,
  input  wire logic i_reset,
  input  wire logic i_ce,
  tbwc_stream_if.snk s_in,
  tbwc_stream_if.src s_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  // Honest flags: full stalls the filler, empty stalls the drain
  assign s_in.ready  = (count_ff != (AW+1)'(DEPTH));
  assign s_out.valid = (count_ff != '0);
  assign s_out.data  = mem_ff[rd_ptr_ff];
  assign push        = i_ce && s_in.valid && s_in.ready;
  assign pop         = i_ce && s_out.valid && s_out.ready;

  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= s_in.data;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule

// >>> src/tbwc_block_write.sv
`timescale 1ns/1ps
`include "tbwc_map.svh"
module tbwc_block_write
  import tbwc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  input  wire logic        i_ce,
  // Command and argument record
  input  wire logic        i_cmd_valid,
  input  wire logic [7:0]  i_cmd_code,
  input  wire logic [7:0]  i_arg_start,
  input  wire logic [7:0]  i_arg_count,
  input  wire logic [7:0]  i_arg_offset,
  input  wire logic [7:0]  i_arg_keysel,
  input  wire logic [47:0] i_arg_key,
  // Status
  output logic             o_busy,
  output logic             o_done,
  output logic [7:0]       o_result,
  // Data buffer read port, data in the same cycle as the strobe
  output logic             o_buf_rd,
  output logic [7:0]       o_buf_addr,
  input  wire logic [7:0]  i_buf_data,
  // Tag authentication
  output logic             o_auth_req,
  output logic [5:0]       o_auth_sector,
  output logic             o_auth_key_b,
  output logic [47:0]      o_auth_key,
  input  wire logic        i_auth_done,
  input  wire logic        i_auth_ok,
  // Tag block write
  output logic             o_wr_req,
  output logic [7:0]       o_wr_blk,
  output logic             o_tag_valid,
  output logic [7:0]       o_tag_byte,
  input  wire logic        i_tag_ready,
  input  wire logic        i_wr_done,
  input  wire logic        i_wr_ok
);
  tbwc_state_type state_ff;
  logic [7:0]  blk_ff;
  logic [7:0]  cnt_ff;
  logic [7:0]  left_ff;
  logic [7:0]  ofs_ff;
  logic [7:0]  keysel_ff;
  logic [47:0] key_ff;
  logic [5:0]  sect_ff;
  logic        authed_ff;
  logic [7:0]  buf_ptr_ff;
  logic [7:0]  addr_ff;
  logic [4:0]  rd_left_ff;
  logic        rd_pend_ff;
  logic        busy_ff;
  logic        done_ff;
  logic [7:0]  result_ff;
  logic        auth_req_ff;
  logic        key_b_ff;
  logic        wr_req_ff;
  logic        tag_valid_ff;
  logic [7:0]  tag_byte_ff;
  logic        skip_blk;
  logic [5:0]  blk_sect;
  logic        use_key;
  logic        overflow;
  logic        rd_go;

  tbwc_stream_if #(.WIDTH(`TBWC_FIFO_WIDTH)) fill_if ();
  tbwc_stream_if #(.WIDTH(`TBWC_FIFO_WIDTH)) drain_if ();

  tbwc_fifo #(
    .WIDTH (`TBWC_FIFO_WIDTH),
    .DEPTH (`TBWC_FIFO_DEPTH)
  ) u_fifo (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_ce    (i_ce),
    .s_in    (fill_if.snk),
    .s_out   (drain_if.src)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Block map: small sectors of 4 below block 128, large sectors of 16 from block 128 up
  assign skip_blk = (blk_ff == 8'h00) ||                                        // RULE12
                    (blk_ff >= `TBWC_BIG_SECT_BLK ? blk_ff[3:0] == 4'hf
                                                  : blk_ff[1:0] == 2'h3);
  assign blk_sect = blk_ff[7] ? {3'b100, blk_ff[6:4]} : {1'b0, blk_ff[6:2]};  // RULE3
  assign use_key  = keysel_ff[`TBWC_KEYSEL_USE];                              // RULE6
  // Host is meant to keep these in range; checked anyway so a bad record cannot wrap
  assign overflow = ({5'h00, ofs_ff} + {cnt_ff, 4'h0}) > `TBWC_BUF_LEN;       // RULE5

  ////////////////////////////////////////////////////////////////////////////////
  // Command sequencing
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      state_ff    <= TBWC_IDLE;
      blk_ff      <= 8'h00;
      cnt_ff      <= 8'h00;
      left_ff     <= 8'h00;
      ofs_ff      <= 8'h00;
      keysel_ff   <= 8'h00;
      key_ff      <= 48'h0;
      sect_ff     <= 6'h00;
      authed_ff   <= 1'b0;
      busy_ff     <= 1'b0;
      done_ff     <= 1'b0;
      result_ff   <= `TBWC_RES_OK;
      auth_req_ff <= 1'b0;
      key_b_ff    <= 1'b0;
      wr_req_ff   <= 1'b0;
    end else if (i_ce) begin
      done_ff     <= 1'b0;
      auth_req_ff <= 1'b0;
      wr_req_ff   <= 1'b0;
      case (state_ff)
        TBWC_IDLE: begin
          if (i_cmd_valid) begin
            busy_ff   <= 1'b1;
            blk_ff    <= i_arg_start;                                         // RULE2
            cnt_ff    <= i_arg_count;
            left_ff   <= i_arg_count;
            ofs_ff    <= i_arg_offset;
            keysel_ff <= i_arg_keysel;
            key_ff    <= i_arg_key;                                           // RULE8
            authed_ff <= 1'b0;
            if (i_cmd_code == `TBWC_CMD_WRITE_BLK) begin                       // RULE1
              state_ff <= TBWC_CHECK;
            end else begin
              result_ff <= `TBWC_RES_BAD_CMD;
              state_ff  <= TBWC_DONE;
            end
          end
        end
        TBWC_CHECK: begin
          if (cnt_ff == 8'h00 || overflow) begin                              // RULE4
            result_ff <= `TBWC_RES_BAD_ARG;
            state_ff  <= TBWC_DONE;
          end else begin
            state_ff <= TBWC_SEEK;
          end
        end
        TBWC_SEEK: begin
          if (skip_blk) begin
            if (blk_ff == 8'hff) begin
              result_ff <= `TBWC_RES_WR_ERR;
              state_ff  <= TBWC_DONE;
            end else begin
              blk_ff <= blk_ff + 8'h01;                                       // RULE12
            end
          end else if (use_key && (!authed_ff || blk_sect != sect_ff)) begin  // RULE9 RULE13
            auth_req_ff <= 1'b1;
            sect_ff     <= blk_sect;
            key_b_ff    <= keysel_ff[`TBWC_KEYSEL_B];                         // RULE7
            state_ff    <= TBWC_AUTH;
          end else begin
            wr_req_ff <= 1'b1;
            state_ff  <= TBWC_WRITE;
          end
        end
        TBWC_AUTH: begin
          if (i_auth_done) begin
            if (i_auth_ok) begin
              authed_ff <= 1'b1;
              wr_req_ff <= 1'b1;
              state_ff  <= TBWC_WRITE;
            end else begin
              result_ff <= `TBWC_RES_AUTH_ERR;                                // RULE10
              state_ff  <= TBWC_DONE;
            end
          end
        end
        TBWC_WRITE: begin
          if (i_wr_done) begin
            if (!i_wr_ok) begin
              result_ff <= `TBWC_RES_WR_ERR;                                  // RULE15
              state_ff  <= TBWC_DONE;
            end else if (left_ff == 8'h01) begin
              result_ff <= `TBWC_RES_OK;                                      // RULE14
              state_ff  <= TBWC_DONE;
            end else begin
              left_ff  <= left_ff - 8'h01;                                    // RULE11
              blk_ff   <= blk_ff + 8'h01;
              state_ff <= TBWC_SEEK;
            end
          end
        end
        TBWC_DONE: begin
          busy_ff  <= 1'b0;
          done_ff  <= 1'b1;
          state_ff <= TBWC_IDLE;
        end
        default: begin
          state_ff <= TBWC_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Buffer reads: one byte in flight, only while the FIFO has room
  assign rd_go         = (state_ff == TBWC_WRITE) && (rd_left_ff != 5'h00) &&
                         !rd_pend_ff && fill_if.ready;
  assign fill_if.valid = rd_pend_ff;
  assign fill_if.data  = i_buf_data;

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      buf_ptr_ff <= 8'h00;
      addr_ff    <= 8'h00;
      rd_left_ff <= 5'h00;
      rd_pend_ff <= 1'b0;
    end else if (i_ce) begin
      rd_pend_ff <= rd_go;
      // Address of the byte in flight, kept in a flop so the port is glitch free
      if (rd_go) begin
        addr_ff <= buf_ptr_ff;
      end
      if (state_ff == TBWC_CHECK) begin
        buf_ptr_ff <= ofs_ff;                                                 // RULE16
      end else if (rd_go) begin
        buf_ptr_ff <= buf_ptr_ff + 8'h01;                                     // RULE16
      end
      if (wr_req_ff) begin
        rd_left_ff <= `TBWC_BLK_BYTES;                                        // RULE16
      end else if (rd_go) begin
        rd_left_ff <= rd_left_ff - 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output stage so tag data leaves from a flop
  assign drain_if.ready = !tag_valid_ff || i_tag_ready;

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      tag_valid_ff <= 1'b0;
      tag_byte_ff  <= 8'h00;
    end else if (i_ce && drain_if.ready) begin
      tag_valid_ff <= drain_if.valid;
      tag_byte_ff  <= drain_if.data;
    end
  end

  assign o_busy        = busy_ff;
  assign o_done        = done_ff;
  assign o_result      = result_ff;
  assign o_buf_rd      = rd_pend_ff;
  assign o_buf_addr    = addr_ff;
  assign o_auth_req    = auth_req_ff;
  assign o_auth_sector = sect_ff;
  assign o_auth_key_b  = key_b_ff;
  assign o_auth_key    = key_ff;
  assign o_wr_req      = wr_req_ff;
  assign o_wr_blk      = blk_ff;
  assign o_tag_valid   = tag_valid_ff;
  assign o_tag_byte    = tag_byte_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  bad_code_a: assert property (i_ce && state_ff == TBWC_IDLE && i_cmd_valid && // RULE1
    i_cmd_code != `TBWC_CMD_WRITE_BLK |=> result_ff == `TBWC_RES_BAD_CMD && state_ff == TBWC_DONE)
    else $error("unknown code not refused");
  zero_count_a: assert property (i_ce && state_ff == TBWC_CHECK && cnt_ff == 8'h00 |=> // RULE4
    result_ff == `TBWC_RES_BAD_ARG && !wr_req_ff)
    else $error("zero count accepted");
  auth_before_a: assert property (wr_req_ff |-> !use_key || // RULE9
    (authed_ff && sect_ff == blk_sect))
    else $error("write before sector authenticated");
  key_kind_a: assert property (auth_req_ff |-> key_b_ff == keysel_ff[`TBWC_KEYSEL_B] && // RULE7
    o_auth_key == key_ff && use_key)
    else $error("wrong key kind");
  auth_fail_a: assert property (i_ce && state_ff == TBWC_AUTH && i_auth_done && // RULE10
    !i_auth_ok |=> result_ff == `TBWC_RES_AUTH_ERR ##1 (done_ff || !i_ce))
    else $error("auth failure not reported");
  no_trailer_a: assert property (wr_req_ff |-> !skip_blk) // RULE12
    else $error("key or lock block written");
  ok_result_a: assert property (i_ce && state_ff == TBWC_WRITE && i_wr_done && // RULE14
    i_wr_ok && left_ff == 8'h01 |=> result_ff == `TBWC_RES_OK && state_ff == TBWC_DONE)
    else $error("no-error result missing");
  wr_fail_a: assert property (i_ce && state_ff == TBWC_WRITE && i_wr_done && !i_wr_ok // RULE15
    |=> result_ff == `TBWC_RES_WR_ERR)
    else $error("write failure not reported");
  buf_step_a: assert property (wr_req_ff |-> buf_ptr_ff == // RULE16
    8'(ofs_ff + ((cnt_ff - left_ff) << 4)))
    else $error("buffer pointer out of step");

  cover_ok_c:    cover property (done_ff && result_ff == `TBWC_RES_OK);
  cover_cross_c: cover property (auth_req_ff && authed_ff);
  cover_auth_c:  cover property (done_ff && result_ff == `TBWC_RES_AUTH_ERR);
endmodule

// >>> testbench/tbwc_tag_model.sv
`timescale 1ns/1ps
module tbwc_tag_model (
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  // Requests from the block
  input  wire logic       i_auth_req,
  input  wire logic [5:0] i_auth_sector,
  input  wire logic       i_wr_req,
  input  wire logic [7:0] i_wr_blk,
  input  wire logic       i_tag_valid,
  // Faults commanded by the bench
  input  wire logic [5:0] i_fail_sector,
  input  wire logic [8:0] i_fail_blk,
  // Answers
  output logic            o_auth_done,
  output logic            o_auth_ok,
  output logic            o_tag_ready,
  output logic            o_wr_done,
  output logic            o_wr_ok
);
  int auth_cnt_ff;
  int byte_cnt_ff;
  int wr_cnt_ff;
  // Qualifiers outside a pulse are noise, so a design reading them late is caught
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      auth_cnt_ff <= 0;
      byte_cnt_ff <= 16;
      wr_cnt_ff   <= 4;
      o_auth_done <= 1'b0;
      o_auth_ok   <= 1'b0;
      o_tag_ready <= 1'b0;
      o_wr_done   <= 1'b0;
      o_wr_ok     <= 1'b0;
    end else begin
      if (i_auth_req) auth_cnt_ff <= 2 + $urandom % 4;
      else if (auth_cnt_ff > 0) auth_cnt_ff <= auth_cnt_ff - 1;
      o_auth_done <= #1 (auth_cnt_ff == 1);
      o_auth_ok   <= #1 (auth_cnt_ff == 1) ? (i_auth_sector != i_fail_sector)
                                           : 1'($urandom);
      if (i_wr_req) begin
        byte_cnt_ff <= 0;
        wr_cnt_ff   <= 0;
      end else if (i_tag_valid && o_tag_ready) byte_cnt_ff <= byte_cnt_ff + 1;
      if (byte_cnt_ff >= 16 && wr_cnt_ff < 4) wr_cnt_ff <= wr_cnt_ff + 1;
      o_tag_ready <= #1 (byte_cnt_ff < 16) && ($urandom % 4 != 0);
      o_wr_done   <= #1 (wr_cnt_ff == 3);
      o_wr_ok     <= #1 (wr_cnt_ff == 3) ? ({1'b0, i_wr_blk} != i_fail_blk)
                                         : 1'($urandom);
    end
  end
endmodule

// >>> testbench/tb_tbwc_block_write.sv
`timescale 1ns/1ps
module tb_tbwc_block_write;
  logic i_mclk = 0, i_reset = 1, i_ce = 1, i_cmd_valid = 0;
  logic [7:0] i_cmd_code = 0, i_arg_start = 0, i_arg_count = 0, i_arg_offset = 0;
  logic [7:0] i_arg_keysel = 0, i_buf_data;
  logic [47:0] i_arg_key = 0, o_auth_key, cur_key;
  logic o_busy, o_done, o_buf_rd, o_auth_req, o_auth_key_b, i_auth_done, i_auth_ok;
  logic o_wr_req, o_tag_valid, i_tag_ready, i_wr_done, i_wr_ok;
  logic [7:0] o_result, o_buf_addr, o_wr_blk, o_tag_byte;
  logic [5:0] o_auth_sector, fail_sector = 6'h3f;
  logic [8:0] fail_blk = 9'h100;
  logic [7:0] buf_mem [256];
  logic [31:0] obs_q [$];
  int exp_q [$];
  int errors = 0, samples_checked = 0, test_no = 0;
  int rd_cnt = 0;
  logic [7:0] rd_addr = 8'h00;
  initial forever #10 i_mclk = ~i_mclk;
  // Buffer answers in the same cycle as the strobe
  assign i_buf_data = buf_mem[o_buf_addr];
  tbwc_block_write u_tbwc_block_write (.i_mclk, .i_reset, .i_ce, .i_cmd_valid, .i_cmd_code,
    .i_arg_start, .i_arg_count, .i_arg_offset, .i_arg_keysel, .i_arg_key, .o_busy, .o_done,
    .o_result, .o_buf_rd, .o_buf_addr, .i_buf_data, .o_auth_req, .o_auth_sector,
    .o_auth_key_b, .o_auth_key, .i_auth_done, .i_auth_ok, .o_wr_req, .o_wr_blk, .o_tag_valid,
    .o_tag_byte, .i_tag_ready, .i_wr_done, .i_wr_ok);
  tbwc_tag_model u_tbwc_tag_model (.i_mclk, .i_reset, .i_auth_req(o_auth_req),
    .i_auth_sector(o_auth_sector), .i_wr_req(o_wr_req), .i_wr_blk(o_wr_blk),
    .i_tag_valid(o_tag_valid), .i_fail_sector(fail_sector), .i_fail_blk(fail_blk),
    .o_auth_done(i_auth_done), .o_auth_ok(i_auth_ok), .o_tag_ready(i_tag_ready),
    .o_wr_done(i_wr_done), .o_wr_ok(i_wr_ok));
  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [47:0] seen, input logic [47:0] expv, input string what);
    samples_checked++;
    if (seen !== expv) begin
      errors++;
      $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, expv);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Event log: auth 0x1000+keyB*0x100+sector, write 0x2000+block, byte 0x3000+value
  always @(posedge i_mclk) begin
    if (!i_reset && o_auth_req) begin
      obs_q.push_back({19'h0, 1'b1, 3'h0, o_auth_key_b, 2'h0, o_auth_sector});
      chk(o_auth_key, cur_key, "auth key");
    end
    if (!i_reset && o_wr_req) obs_q.push_back({18'h0, 2'b10, 4'h0, o_wr_blk});
    if (!i_reset && o_tag_valid && i_tag_ready) obs_q.push_back({18'h0, 2'b11, 4'h0, o_tag_byte});
    if (!i_reset && o_buf_rd) begin
      chk(o_buf_addr, rd_addr, "buffer address");
      rd_addr++;
      rd_cnt++;
    end
  end
  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic model_cmd(input int code, st, cnt, off, ks, output int res);
    int blk, sec, cur, n;
    exp_q.delete();
    res = 0;
    blk = st;
    cur = -1;
    n = 0;
    if (code != 5) begin res = 1; return; end
    if (cnt == 0 || off + 16 * cnt > 256) begin res = 2; return; end
    while (n < cnt) begin
      while (blk == 0 || (blk < 128 ? blk % 4 == 3 : blk % 16 == 15)) blk++;
      if (blk > 255) begin res = 4; return; end
      sec = blk < 128 ? blk / 4 : 32 + (blk - 128) / 16;
      if (ks[6] && sec != cur) begin
        exp_q.push_back('h1000 + ks[7] * 256 + sec);
        if (sec == fail_sector) begin res = 3; return; end
        cur = sec;
      end
      exp_q.push_back('h2000 + blk);
      for (int k = 0; k < 16; k++) exp_q.push_back('h3000 + buf_mem[off + 16 * n + k]);
      if (blk == fail_blk) begin res = 4; return; end
      blk++;
      n++;
    end
  endtask
  // Arguments change only between commands, so a design sampling them late still sees them
  task automatic run_cmd(input int code, st, cnt, off, ks);
    int res, t, nrd;
    cur_key = {16'($urandom), $urandom};
    model_cmd(code, st, cnt, off, ks, res);
    obs_q.delete();
    rd_cnt = 0;
    rd_addr = 8'(off);
    i_cmd_valid = 1;
    i_cmd_code = 8'(code);
    i_arg_start = 8'(st);
    i_arg_count = 8'(cnt);
    i_arg_offset = 8'(off);
    i_arg_keysel = 8'(ks);
    i_arg_key = cur_key;
    @(posedge i_mclk) #1;
    i_cmd_valid = 0;
    chk(o_busy, 1, "busy");
    @(posedge i_mclk) #1;
    if (o_busy === 1'b1) begin
      i_cmd_valid = 1;
      i_cmd_code = 8'h07;
      @(posedge i_mclk) #1;
      i_cmd_valid = 0;
    end
    t = 0;
    while (o_done !== 1'b1 && t < 5000) begin
      @(posedge i_mclk) #1;
      t++;
    end
    chk(o_result, res, "result");
    chk(obs_q.size(), exp_q.size(), "event count");
    foreach (exp_q[i]) if (i < obs_q.size()) chk(obs_q[i], exp_q[i], "event");
    nrd = 0;
    foreach (exp_q[i]) if (exp_q[i] >= 'h3000) nrd++;
    chk(rd_cnt, nrd, "buffer reads");
    test_no++;
    $display("test %0d ended, result %0h", test_no, o_result);
    @(posedge i_mclk) #1;
  endtask
  //////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(3));
    foreach (buf_mem[i]) buf_mem[i] = 8'($urandom);
    repeat (16) @(posedge i_mclk);
    #1 i_reset = 0;
    // Enable low must freeze the block, so a strobe then is not taken
    i_ce = 0;
    i_cmd_valid = 1;
    i_cmd_code = 8'h05;
    i_arg_count = 8'h01;
    repeat (2) @(posedge i_mclk) #1;
    chk(o_busy, 0, "frozen accept");
    i_cmd_valid = 0;
    i_ce = 1;
    @(posedge i_mclk) #1;
    run_cmd(7, 1, 1, 0, 'h40);
    run_cmd(5, 1, 0, 0, 'h40);
    run_cmd(5, 1, 2, 'hf0, 'h40);
    run_cmd(5, 1, 1, 0, 'h40);
    run_cmd(5, 2, 4, 'h10, 'hc0);
    run_cmd(5, 125, 3, 0, 'h00);
    fail_sector = 6'h01;
    run_cmd(5, 2, 4, 0, 'h40);
    fail_sector = 6'h3f;
    fail_blk = 9'h005;
    run_cmd(5, 3, 3, 0, 'hc0);
    fail_blk = 9'h100;
    run_cmd(5, 254, 2, 0, 'h40);
    repeat (4) begin
      run_cmd(5, $urandom % 250, 1 + $urandom % 3, $urandom % 160,
              'h40 + 'h80 * ($urandom % 2));
    end
    wrap_up();
  end
  // Hang guard, well past the longest expected run
  initial begin
    repeat (60000) @(posedge i_mclk);
    errors++;
    wrap_up();
  end
endmodule
